// ===== logic/usf_pkg.sv
// Shared constants and types for the sample frame framer.
package usf_pkg;
	// ==========================================================
	// Frame geometry
	// ==========================================================
	localparam logic [8:0] POS_LAST = 9'h1FF; // Last byte of a 512-byte frame.
	localparam logic [8:0] POS_SEL = 9'h003; // Selector byte position.
	localparam logic [8:0] POS_PAY1 = 9'h004; // First payload byte position.
	localparam logic [8:0] POS_DATA = 9'h008; // First sample group byte.
	localparam logic [7:0] SYNC_HI = 8'h80; // First sync byte.
	localparam logic [7:0] SYNC_LO = 8'h00; // Second and third sync bytes.
	localparam logic [2:0] SUB_LAST = 3'h7; // Last byte of an 8-byte group.
	// ==========================================================
	// Selector byte
	// ==========================================================
	localparam logic [5:0] SEL_STATUS = 6'h00; // Downstream: carries converter speed.
	localparam logic [5:0] SEL_POWER = 6'h01; // Forward and reflected power.
	localparam logic [5:0] SEL_FREQ = 6'h03; // Measured frequency in hertz.
	localparam int SEL_KEY_BIT = 0; // Push-to-talk or dot key.
	localparam int SEL_DASH_BIT = 1; // Dash key.
	// ==========================================================
	// Register map on the AXI4-Lite slave
	// ==========================================================
	localparam logic [7:0] REG_CTRL = 8'h00; // Control, read and write.
	localparam logic [7:0] REG_STATUS = 8'h04; // Link state, read only.
	localparam logic [7:0] REG_UP_FRAMES = 8'h08; // Upstream frames sent.
	localparam logic [7:0] REG_DN_FRAMES = 8'h0C; // Downstream frames accepted.
	localparam logic [7:0] REG_SYNC_LOSS = 8'h10; // Times lock was lost.
	localparam logic [1:0] CTRL_RESET = 2'h3; // Upstream on, rotation on.
	localparam int CTRL_UPEN_BIT = 0; // Upstream frame generation enable.
	localparam int CTRL_ROT_BIT = 1; // Rotate power and frequency status.
	localparam logic [1:0] RATE_RESET = 2'h0; // Converter speed after reset.
	localparam logic [1:0] RESP_OKAY = 2'h0; // AXI OKAY response.
	localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI SLVERR response.
	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {
		USF_HUNT = 2'b00,
		USF_CHECK = 2'b01,
		USF_LOCKED = 2'b10
	} usf_lock_t;
	typedef struct packed {
		logic [23:0] i;
		logic [23:0] q;
		logic [15:0] mic;
	} usf_up_smp_t;
	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
		logic [15:0] tx_i;
		logic [15:0] tx_q;
	} usf_dn_smp_t;
endpackage

// ===== logic/usf_framer.sv
// Upstream frame builder, downstream frame parser and AXI4-Lite registers.
// Functional notes
// RQ1 - Frames are exactly 512 bytes both ways.
// RQ2 - Frames open with 0x80, 0x00, 0x00.
// RQ3 - Lock only after sync recurs 512 bytes later.
// RQ4 - Key state every frame, status rotates.
// RQ5 - Control bytes never mimic the sync.
// RQ6 - Upstream: 63 groups of I, Q, mic.
// RQ7 - Upstream samples go most significant byte first.
// RQ8 - Receiver samples 24 bits, rate 48/96/192k.
// RQ9 - Microphone samples 16 bits at 48k.
// RQ10 - Selector bit0 key/dot, bit1 dash.
// RQ11 - Selector bits 7-2 give payload meaning.
// RQ12 - Code 1: forward then reflected power.
// RQ13 - Code 3: 32-bit frequency, MSB first.
// RQ14 - Host sends receive audio and transmit audio.
// RQ15 - Downstream groups: left, right, I, Q.
// RQ16 - Downstream samples arrive high byte first.
// RQ17 - Downstream header: sync then five commands.
// RQ18 - Downstream selector bit0 requests transmit.
// RQ19 - Code 0: first payload bits 1-0 speed.
// RQ20 - Missing sync at boundary drops lock.
// RQ21 - Undefined payload bytes are sent as zero.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
module usf_framer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire usf_pkg::usf_up_smp_t smp_in,
	input wire logic smp_valid,
	output logic smp_ready,
	input wire logic ptt_in,
	input wire logic dash_in,
	input wire logic [15:0] fwd_pwr,
	input wire logic [15:0] rev_pwr,
	input wire logic [31:0] freq_hz,
	output logic [7:0] up_tdata,
	output logic up_tvalid,
	input wire logic up_tready,
	input wire logic [7:0] dn_tdata,
	input wire logic dn_tvalid,
	output logic dn_tready,
	output usf_pkg::usf_dn_smp_t dn_audio,
	output logic dn_audio_valid,
	output logic mox,
	output logic [1:0] adc_rate,
	output logic frame_lock
);
	// ==========================================================
	// Functions
	// ==========================================================
	// Breaks any 80 00 00 run among the payload bytes by nudging the 0x80 to 0x7F.
	// The selector byte can never be 0x80 since codes 1 and 3 are the only ones sent.
	function automatic logic [31:0] usf_nosync(input logic [31:0] p);
		logic [31:0] r;
		r = p;
		if (r[31:8] == {usf_pkg::SYNC_HI, usf_pkg::SYNC_LO, usf_pkg::SYNC_LO}) begin
			r[31:24] = r[31:24] - 8'h01;
		end
		if (r[23:0] == {usf_pkg::SYNC_HI, usf_pkg::SYNC_LO, usf_pkg::SYNC_LO}) begin
			r[23:16] = r[23:16] - 8'h01;
		end
		return r;
	endfunction
	// True for addresses that the register file decodes.
	function automatic logic usf_mapped(input logic [7:0] a);
		return (a == usf_pkg::REG_CTRL) || (a == usf_pkg::REG_STATUS) ||
			(a == usf_pkg::REG_UP_FRAMES) || (a == usf_pkg::REG_DN_FRAMES) ||
			(a == usf_pkg::REG_SYNC_LOSS);
	endfunction
	// ==========================================================
	// Register file state
	// ==========================================================
	logic [1:0] ctrl; // Upstream enable and status rotation.
	logic [31:0] up_frames; // Upstream frames completed.
	logic [31:0] dn_frames; // Downstream frames accepted under lock.
	logic [31:0] sync_loss; // Lock losses.
	logic aw_hold; // Write address captured.
	logic w_hold; // Write data captured.
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	// Writes complete only when both halves are held and no response is pending.
	wire do_write = aw_hold && w_hold && !s_axi_bvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [31:0] status_word = {28'h0000000, adc_rate, mox, frame_lock};
	wire [31:0] rd_mux = (s_axi_araddr == usf_pkg::REG_CTRL) ? {30'h00000000, ctrl} :
		(s_axi_araddr == usf_pkg::REG_STATUS) ? status_word :
		(s_axi_araddr == usf_pkg::REG_UP_FRAMES) ? up_frames :
		(s_axi_araddr == usf_pkg::REG_DN_FRAMES) ? dn_frames :
		(s_axi_araddr == usf_pkg::REG_SYNC_LOSS) ? sync_loss : 32'h00000000;
	assign s_axi_awready = !aw_hold;
	assign s_axi_wready = !w_hold;
	assign s_axi_arready = !s_axi_rvalid;
	// Write channel: address and data are taken in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= usf_pkg::RESP_OKAY;
			ctrl <= usf_pkg::CTRL_RESET;
		end else begin
			if (s_axi_awvalid && !aw_hold) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Read-only registers accept and ignore writes; holes answer SLVERR.
				s_axi_bresp <= usf_mapped(aw_addr) ? usf_pkg::RESP_OKAY : usf_pkg::RESP_SLVERR;
				if (aw_addr == usf_pkg::REG_CTRL && w_strb[0]) begin
					ctrl <= w_data[1:0];
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// Read channel: one cycle from address to data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= usf_pkg::RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= usf_mapped(s_axi_araddr) ? usf_pkg::RESP_OKAY : usf_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// ==========================================================
	// Upstream frame builder
	// ==========================================================
	logic [8:0] up_pos; // Position of the next byte to load.
	logic [39:0] hdr; // Selector and four payload bytes for this frame.
	logic phase; // Rotation phase: 0 power, 1 frequency.
	logic have_smp; // A sample group is held.
	usf_pkg::usf_up_smp_t smp_q; // Held sample group.
	wire up_in_data = (up_pos >= usf_pkg::POS_DATA);
	wire [2:0] up_sub = up_pos[2:0];
	// A frame only starts when enabled; once started it always runs to 512 bytes.
	wire up_go = (up_pos != 9'h000) || ctrl[usf_pkg::CTRL_UPEN_BIT]; // RQ1
	wire up_avail = !up_in_data || have_smp;
	wire up_load = up_go && up_avail && (!up_tvalid || up_tready);
	// Status rotates between power and frequency; key bits ride in every frame.
	wire [5:0] next_code = (ctrl[usf_pkg::CTRL_ROT_BIT] && phase) ? usf_pkg::SEL_FREQ :
		usf_pkg::SEL_POWER; // RQ4 RQ11
	wire [31:0] raw_pay = (next_code == usf_pkg::SEL_POWER) ? {fwd_pwr, rev_pwr} : // RQ12
		(next_code == usf_pkg::SEL_FREQ) ? freq_hz : 32'h00000000; // RQ13 RQ21
	wire [39:0] next_hdr = {next_code, dash_in, ptt_in, usf_nosync(raw_pay)}; // RQ10 RQ5
	// Group bytes: I, Q, then mic, each most significant byte first.
	wire [63:0] grp = smp_q; // RQ6 RQ8 RQ9
	wire [7:0] grp_byte = grp[8'd63 - {up_sub, 3'b000} -: 8]; // RQ7
	wire [7:0] hdr_byte = hdr[8'd39 - {up_pos[2:0] - 3'h3, 3'b000} -: 8];
	wire [7:0] sync_byte = (up_pos == 9'h000) ? usf_pkg::SYNC_HI : usf_pkg::SYNC_LO; // RQ2
	wire [7:0] next_byte = up_in_data ? grp_byte :
		(up_pos < usf_pkg::POS_SEL) ? sync_byte : hdr_byte;
	assign smp_ready = !have_smp;
	// Output register stage: byte and valid come from flip-flops.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_pos <= 9'h000;
			up_tdata <= 8'h00;
			up_tvalid <= 1'b0;
			hdr <= 40'h0000000000;
			phase <= 1'b0;
			up_frames <= 32'h00000000;
		end else if (up_load) begin
			up_tdata <= next_byte;
			up_tvalid <= 1'b1;
			up_pos <= (up_pos == usf_pkg::POS_LAST) ? 9'h000 : up_pos + 9'h001; // RQ1
			if (up_pos == 9'h000) begin
				hdr <= next_hdr;
				phase <= !phase;
			end
			if (up_pos == usf_pkg::POS_LAST) begin
				up_frames <= up_frames + 32'h00000001;
			end
		end else if (up_tready) begin
			up_tvalid <= 1'b0;
		end
	end
	// Sample group holder; released once its last byte is loaded.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_smp <= 1'b0;
			smp_q <= '0;
		end else if (smp_valid && smp_ready) begin
			have_smp <= 1'b1;
			smp_q <= smp_in;
		end else if (up_load && up_in_data && up_sub == usf_pkg::SUB_LAST) begin
			have_smp <= 1'b0; // RQ6
		end
	end
	// ==========================================================
	// Downstream frame parser
	// ==========================================================
	usf_pkg::usf_lock_t lock_st; // Sync search state.
	logic [8:0] dn_pos; // Position of the incoming byte.
	logic [15:0] dn_hist; // Two previous bytes for the sync search.
	logic [55:0] dn_acc; // Partial audio group.
	logic [5:0] dn_code; // Selector code of the current frame.
	wire [7:0] exp_sync = (dn_pos == 9'h000) ? usf_pkg::SYNC_HI : usf_pkg::SYNC_LO;
	wire sync_seen = {dn_hist, dn_tdata} ==
		{usf_pkg::SYNC_HI, usf_pkg::SYNC_LO, usf_pkg::SYNC_LO};
	wire at_sync = (dn_pos < usf_pkg::POS_SEL);
	wire sync_bad = at_sync && (dn_tdata != exp_sync);
	wire locked = (lock_st == usf_pkg::USF_LOCKED);
	assign dn_tready = 1'b1;
	assign frame_lock = locked;
	// Lock needs two syncs 512 bytes apart; one miss at a boundary drops it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_st <= usf_pkg::USF_HUNT;
			dn_pos <= 9'h000;
			dn_hist <= 16'h0000;
			sync_loss <= 32'h00000000;
			dn_frames <= 32'h00000000;
		end else if (dn_tvalid) begin
			dn_hist <= {dn_hist[7:0], dn_tdata};
			dn_pos <= (dn_pos == usf_pkg::POS_LAST) ? 9'h000 : dn_pos + 9'h001;
			case (lock_st)
				usf_pkg::USF_HUNT: begin
					if (sync_seen) begin
						lock_st <= usf_pkg::USF_CHECK;
					end
					dn_pos <= usf_pkg::POS_SEL;
				end
				usf_pkg::USF_CHECK: begin
					if (sync_bad) begin
						lock_st <= usf_pkg::USF_HUNT; // RQ20
					end else if (dn_pos == 9'h002) begin
						lock_st <= usf_pkg::USF_LOCKED; // RQ3
					end
				end
				usf_pkg::USF_LOCKED: begin
					if (sync_bad) begin
						lock_st <= usf_pkg::USF_HUNT; // RQ20
						sync_loss <= sync_loss + 32'h00000001;
					end
					if (dn_pos == usf_pkg::POS_LAST) begin
						dn_frames <= dn_frames + 32'h00000001;
					end
				end
				default: begin
					lock_st <= usf_pkg::USF_HUNT;
				end
			endcase
		end
	end
	// Commands and audio are used only from frames that arrive under lock.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mox <= 1'b0;
			adc_rate <= usf_pkg::RATE_RESET;
			dn_code <= 6'h00;
			dn_acc <= 56'h00000000000000;
			dn_audio <= '0;
			dn_audio_valid <= 1'b0;
		end else begin
			dn_audio_valid <= 1'b0;
			if (dn_tvalid && locked) begin
				if (dn_pos == usf_pkg::POS_SEL) begin
					mox <= dn_tdata[usf_pkg::SEL_KEY_BIT]; // RQ17 RQ18
					dn_code <= dn_tdata[7:2];
				end
				if (dn_pos == usf_pkg::POS_PAY1 && dn_code == usf_pkg::SEL_STATUS) begin
					adc_rate <= dn_tdata[1:0]; // RQ19
				end
				if (dn_pos >= usf_pkg::POS_DATA) begin
					dn_acc <= {dn_acc[47:0], dn_tdata}; // RQ16
					if (dn_pos[2:0] == usf_pkg::SUB_LAST) begin
						dn_audio <= {dn_acc, dn_tdata}; // RQ14 RQ15
						dn_audio_valid <= 1'b1;
					end
				end
			end
		end
	end
	// ==========================================================
	// Assertions
	// ==========================================================
	property p_frame_wrap;
		@(posedge aclk) disable iff (!aresetn)
		(up_load && up_pos == usf_pkg::POS_LAST) |=> (up_pos == 9'h000);
	endproperty
	a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap"); // RQ1
	property p_sync_head;
		@(posedge aclk) disable iff (!aresetn)
		(up_load && up_pos == 9'h000) |=> (up_tdata == usf_pkg::SYNC_HI)
			##0 (up_pos == 9'h001);
	endproperty
	a_sync_head: assert property (p_sync_head) else $error("bad first sync byte"); // RQ2
	property p_lock_pos;
		@(posedge aclk) disable iff (!aresetn)
		$rose(frame_lock) |-> (dn_pos == usf_pkg::POS_SEL) && $past(lock_st) == usf_pkg::USF_CHECK;
	endproperty
	a_lock_pos: assert property (p_lock_pos) else $error("lock not at boundary"); // RQ3
	property p_key_bit;
		@(posedge aclk) disable iff (!aresetn)
		(up_load && up_pos == 9'h000) |=> (hdr[32] == $past(ptt_in)) && (hdr[33] == $past(dash_in));
	endproperty
	a_key_bit: assert property (p_key_bit) else $error("key bits wrong"); // RQ10
	property p_code_legal;
		@(posedge aclk) disable iff (!aresetn)
		(up_pos > usf_pkg::POS_SEL) |-> (hdr[39:34] == usf_pkg::SEL_POWER) ||
			(hdr[39:34] == usf_pkg::SEL_FREQ);
	endproperty
	a_code_legal: assert property (p_code_legal) else $error("bad selector code"); // RQ11
	property p_nosync;
		@(posedge aclk) disable iff (!aresetn)
		hdr[31:8] != 24'h800000 && hdr[23:0] != 24'h800000;
	endproperty
	a_nosync: assert property (p_nosync) else $error("header mimics sync"); // RQ5
	property p_msb_first;
		@(posedge aclk) disable iff (!aresetn)
		(up_load && up_in_data && up_sub == 3'h0) |=> (up_tdata == smp_q.i[23:16]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("I high byte not first"); // RQ7
	property p_loss;
		@(posedge aclk) disable iff (!aresetn)
		(locked && dn_tvalid && sync_bad) |=> (lock_st == usf_pkg::USF_HUNT) && !frame_lock;
	endproperty
	a_loss: assert property (p_loss) else $error("lock kept after bad sync"); // RQ20
	property p_rate;
		@(posedge aclk) disable iff (!aresetn)
		(locked && dn_tvalid && dn_pos == usf_pkg::POS_PAY1 && dn_code == usf_pkg::SEL_STATUS)
			|=> (adc_rate == $past(dn_tdata[1:0]));
	endproperty
	a_rate: assert property (p_rate) else $error("speed not applied"); // RQ19
	c_lock: cover property (@(posedge aclk) disable iff (!aresetn) $rose(frame_lock));
	c_up_frame: cover property (@(posedge aclk) disable iff (!aresetn)
		up_load && up_pos == usf_pkg::POS_LAST);
	c_audio: cover property (@(posedge aclk) disable iff (!aresetn) dn_audio_valid);
	c_loss: cover property (@(posedge aclk) disable iff (!aresetn) $fell(frame_lock));
endmodule // usf_framer

// ===== verif/usf_host_model.sv
// Host-side partner: drains upstream bytes and sends downstream frames.
module usf_host_model (
	input wire logic aclk,
	input wire logic [7:0] up_tdata,
	input wire logic up_tvalid,
	output logic up_tready,
	output logic [7:0] dn_tdata,
	output logic dn_tvalid,
	input wire logic dn_tready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Upstream sink
	// ==========================================
	logic [7:0] up_q[$]; // Bytes taken from the device, in order.
	initial begin
		up_tready = 1'b0;
		dn_tvalid = 1'b0;
		dn_tdata = 8'h00;
	end
	// Random stalls force the device to hold a byte across edges.
	always @(posedge aclk) begin
		if (up_tvalid && up_tready)
			up_q.push_back(up_tdata);
		up_tready <= ($urandom_range(3) != 0);
	end
	// ==========================================
	// Downstream source
	// ==========================================
	// One byte per accepted edge; the caller enters just after an edge.
	task automatic send_byte(input logic [7:0] b);
		dn_tdata <= b;
		dn_tvalid <= 1'b1;
		@(posedge aclk);
		while (!dn_tready) @(posedge aclk);
	endtask
	// A whole 512-byte frame; idle data is inverted so a stale byte never looks valid.
	task automatic send_frame(input logic [7:0] b0, input logic [7:0] sel,
		input logic [7:0] c1, input logic [15:0] au[252]);
		send_byte(b0);
		send_byte(8'h00);
		send_byte(8'h00);
		send_byte(sel);
		send_byte(c1);
		repeat (3) send_byte(8'h00);
		for (int n = 0; n < 252; n++) begin
			send_byte(au[n][15:8]);
			send_byte(au[n][7:0]);
		end
		dn_tvalid <= 1'b0;
		dn_tdata <= ~dn_tdata;
	endtask
endmodule // usf_host_model

// ===== verif/tb_usf_framer.sv
// Self-checking bench for the sample frame framer.
module tb_usf_framer;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Signals
	// ==========================================
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, up_tdata, dn_tdata;
	logic [31:0] s_axi_wdata, s_axi_rdata, freq_hz;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, adc_rate;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, smp_ready, ptt_in, dash_in;
	logic up_tvalid, up_tready, dn_tvalid, dn_tready, dn_audio_valid, mox, frame_lock;
	logic [15:0] fwd_pwr, rev_pwr;
	logic smp_valid = 1'b0; // Sample group offer.
	usf_pkg::usf_up_smp_t smp_in = '0;
	usf_pkg::usf_dn_smp_t dn_audio;
	usf_pkg::usf_up_smp_t grp_q[$]; // Groups in the order the device took them.
	usf_pkg::usf_dn_smp_t aud_q[$]; // Audio the device must deliver.
	int miscompares, samples_checked, frames_up;
	usf_framer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .smp_in, .smp_valid,
		.smp_ready, .ptt_in, .dash_in, .fwd_pwr, .rev_pwr, .freq_hz, .up_tdata,
		.up_tvalid, .up_tready, .dn_tdata, .dn_tvalid, .dn_tready, .dn_audio,
		.dn_audio_valid, .mox, .adc_rate, .frame_lock);
	usf_host_model host (.aclk, .up_tdata, .up_tvalid, .up_tready, .dn_tdata,
		.dn_tvalid, .dn_tready);
	// ==========================================
	// Clock, watchdog, reporting
	// ==========================================
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// The tests need about 10k cycles; a hang is cut well after that.
	initial begin
		repeat (40000) @(posedge aclk);
		miscompares++;
		wrap_up();
	end
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ==========================================
	// AXI4-Lite master
	// ==========================================
	// Address and data are offered together; each drops only when taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw = 1'b0;
		bit w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		check(name, s_axi_rdata, exp);
		check(name, s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask
	// ==========================================
	// Stimulus helpers and reference model
	// ==========================================
	// Random groups are offered continuously and logged when taken.
	always @(posedge aclk) begin
		if (aresetn && smp_valid && smp_ready)
			grp_q.push_back(smp_in);
		if (!smp_valid || smp_ready) begin
			smp_in <= {$urandom, $urandom};
			smp_valid <= aresetn;
		end
	end
	always @(posedge aclk)
		if (dn_audio_valid === 1'b1)
			check("dn_audio", dn_audio, aud_q.pop_front());
	// Rebuilds upstream frame k from the levels held during its phase.
	task automatic chk_up(input int k);
		logic [7:0] b[512];
		logic [31:0] p;
		logic [63:0] v;
		logic [5:0] code;
		for (int n = 0; n < 512; n++) b[n] = host.up_q[k * 512 + n];
		code = (k % 2 == 0) ? usf_pkg::SEL_POWER : usf_pkg::SEL_FREQ;
		p = (k % 2 == 0) ? {fwd_pwr, rev_pwr} : freq_hz;
		if (p[31:8] == 24'h800000) p[31:24] = 8'h7F;
		else if (p[23:0] == 24'h800000) p[23:16] = 8'h7F;
		check("sync", {b[0], b[1], b[2]}, 24'h800000);
		check("selector", b[3], {code, dash_in, ptt_in});
		check("payload", {b[4], b[5], b[6], b[7]}, p);
		for (int j = 0; j < 63; j++) begin
			for (int m = 0; m < 8; m++) v = {v[55:0], b[8 * j + 8 + m]};
			check("group", v, grp_q.pop_front());
		end
	endtask
	// Runs at least two frames, stops, and checks every whole frame.
	task automatic run_up();
		int k0;
		logic [1:0] r;
		k0 = frames_up;
		axi_wr(usf_pkg::REG_CTRL, 32'h3, r);
		while (host.up_q.size() < (k0 + 2) * 512) @(posedge aclk);
		axi_wr(usf_pkg::REG_CTRL, 32'h2, r);
		// The valid flag also drops between groups, so wait for the byte position to wrap too.
		do @(posedge aclk); while (up_tvalid !== 1'b0 || DUT.up_pos !== 9'h000);
		frames_up = host.up_q.size() / 512;
		check("up_len", host.up_q.size() % 512, 0);
		for (int k = k0; k < frames_up; k++) chk_up(k);
		rd_chk("up_frames", usf_pkg::REG_UP_FRAMES, frames_up, usf_pkg::RESP_OKAY);
	endtask
	// ==========================================
	// Main sequence
	// ==========================================
	initial begin
		logic [1:0] r;
		logic [15:0] au[252];
		logic [7:0] sel, c1;
		logic e_mox, ok;
		logic [1:0] e_rate;
		void'($urandom(32'h6A09));
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, dash_in} = '0;
		s_axi_wstrb = 4'hF;
		ptt_in = 1'b1;
		{fwd_pwr, rev_pwr, freq_hz} = {$urandom, $urandom};
		{e_mox, e_rate, frames_up} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk("ctrl", usf_pkg::REG_CTRL, 32'h3, usf_pkg::RESP_OKAY);
		rd_chk("unmapped", 8'h20, 32'h0, usf_pkg::RESP_SLVERR);
		axi_wr(8'h20, 32'hFFFFFFFF, r);
		check("wr_resp", r, usf_pkg::RESP_SLVERR);
		run_up();
		// Second phase: other key levels, payloads that would mimic the sync.
		ptt_in <= 1'b0;
		dash_in <= 1'b1;
		fwd_pwr <= 16'h0080;
		rev_pwr <= 16'h0000;
		freq_hz <= 32'h00800000;
		@(posedge aclk);
		run_up();
		// Frame 0 cannot lock, 1..4 are locked, 5 has a broken sync.
		for (int f = 0; f < 6; f++) begin
			sel = (f > 3) ? 8'h0D : {7'h00, f[0]};
			c1 = (f == 0) ? 8'h01 : (f > 3) ? 8'h00 : 8'(f - 1);
			ok = (f > 0 && f < 5);
			if (ok) e_mox = sel[0];
			if (ok && f < 4) e_rate = c1[1:0];
			for (int n = 0; n < 252; n++) au[n] = 16'($urandom) & 16'h7F7F;
			for (int j = 0; j < 63 && ok; j++)
				aud_q.push_back({au[4 * j], au[4 * j + 1], au[4 * j + 2], au[4 * j + 3]});
			@(posedge aclk);
			host.send_frame((f == 5) ? 8'h81 : 8'h80, sel, c1, au);
			repeat (2) @(posedge aclk);
			check("frame_lock", frame_lock, ok);
			check("mox", mox, e_mox);
			check("adc_rate", adc_rate, e_rate);
		end
		check("audio_left", aud_q.size(), 0);
		rd_chk("sync_loss", usf_pkg::REG_SYNC_LOSS, 32'h1, usf_pkg::RESP_OKAY);
		rd_chk("dn_frames", usf_pkg::REG_DN_FRAMES, 32'h4, usf_pkg::RESP_OKAY);
		rd_chk("status", usf_pkg::REG_STATUS, 32'hA, usf_pkg::RESP_OKAY);
		wrap_up();
	end
endmodule // tb_usf_framer
